// *** hw/omcc_top.sv ***
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module omcc_top
    import omcc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        halt_i,
    input  wire logic        wdt_enabled_i,
    input  wire logic        clr_wdt_i,
    input  wire logic        wdt_overflow_i,
    input  wire logic        wdt_ctrl_reset_i,
    input  wire logic        lvr_event_i,
    input  wire logic        irq_wake_i,
    input  wire logic [7:0]  porta_pin_i,
    input  wire logic [7:0]  porta_wake_en_i,
    output logic             sys_tick_o,
    output logic             cpu_run_o,
    output logic             tbc_run_o,
    output logic             slow_internal_osc_tick_o,
    output logic             fast_div16_tick_o,
    output logic             fast_div64_tick_o,
    output logic             wdt_clear_o,
    output logic             wdt_hold_o,
    output logic             power_down_flag_o,
    output logic             watchdog_expiry_flag_o,
    output logic [2:0]       mode_o,
    output logic             irq_o
);

    omcc_osc_if fast_if ();
    omcc_osc_if slow_if ();

    omcc_osc #(.DIV(FAST_DIV), .START(FAST_START_TICKS)) u_fast (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .port_o (fast_if)
    );

    omcc_osc #(.DIV(SLOW_DIV), .START(SLOW_START_TICKS)) u_slow (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .port_o (slow_if)
    );

    omcc_mode_t         mode_reg;
    logic [2:0]         cks_reg;
    logic               idle_enable_on_halt_reg;
    logic               high_clock_select_reg;
    logic               idle_system_clock_keep_reg;
    logic               d3_reg;
    logic               low_voltage_reset_flag_reg;
    logic               wrf_reg;
    logic [IRQ_W-1:0]   irq_st_reg;
    logic [IRQ_W-1:0]   irq_msk_reg;
    logic               ack_reg;
    logic [31:0]        rdata_reg;
    logic [31:0]        rdata_next;
    logic [2:0]         cks_act_reg;
    logic               hl_act_reg;
    logic [FDIV_W-1:0]  fdiv_reg;
    logic [FDIV_W-1:0]  div_mask;
    logic [GAP_W-1:0]   gap_reg;
    logic               sys_tick_reg;
    logic               cpu_run_reg;
    logic               tbc_run_reg;
    logic               wdt_clear_reg;
    logic               wdt_hold_reg;
    logic               pdf_reg;
    logic               to_reg;
    logic               irq_reg;
    logic               div16_reg;
    logic               div64_reg;
    logic               hto_d_reg;
    logic               lto_d_reg;
    logic [7:0]         pa_s1_reg;
    logic [7:0]         pa_s2_reg;
    logic [7:0]         pa_s3_reg;

    logic bus_req;
    logic wr_en;
    logic halt_take;
    logic wake;
    logic sys_on;
    logic tgt_fast;
    logic act_fast;
    logic src_tick;
    logic sw_ok;
    logic [IRQ_W-1:0] irq_ev;

    assign bus_req   = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_en     = bus_req && wb_we_i && wb_sel_i[0];
    assign halt_take = halt_i && (mode_reg == MODE_RUN);
    assign wake      = (|(pa_s3_reg & ~pa_s2_reg & porta_wake_en_i))
                       || irq_wake_i || wdt_overflow_i;
    assign sys_on    = (mode_reg == MODE_RUN) || (mode_reg == MODE_IDLE_CLOCK_ON_MODE);
    assign tgt_fast  = high_clock_select_reg || (cks_reg >= CKS_FIRST_FAST);
    assign act_fast  = hl_act_reg || (cks_act_reg >= CKS_FIRST_FAST);

    // ---------------------------------------------------------------
    // Port A synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_s1_reg <= 8'hff;
            pa_s2_reg <= 8'hff;
            pa_s3_reg <= 8'hff;
        end else begin
            pa_s1_reg <= porta_pin_i;
            pa_s2_reg <= pa_s1_reg;
            pa_s3_reg <= pa_s2_reg;
        end
    end

    // ---------------------------------------------------------------
    // Operating mode
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg <= MODE_RUN;
        end else begin
            case (mode_reg)
                MODE_RUN: begin
                    if (halt_take) begin
                        if (!idle_enable_on_halt_reg && !wdt_enabled_i) begin
                            mode_reg <= MODE_DEEP_SLEEP_MODE;
                        end else if (!idle_enable_on_halt_reg) begin
                            mode_reg <= MODE_SLEEP_WITH_WATCHDOG_MODE;
                        end else if (!idle_system_clock_keep_reg) begin
                            mode_reg <= MODE_IDLE_CLOCK_OFF_MODE;
                        end else begin
                            mode_reg <= MODE_IDLE_CLOCK_ON_MODE;
                        end
                    end
                end
                default: begin
                    if (wake) begin
                        mode_reg <= MODE_RUN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_run_reg   <= 1'b1;
            tbc_run_reg   <= 1'b1;
            wdt_clear_reg <= 1'b0;
            wdt_hold_reg  <= 1'b0;
        end else begin
            wdt_clear_reg <= halt_take;
            if (halt_take) begin
                cpu_run_reg  <= 1'b0;
                tbc_run_reg  <= idle_enable_on_halt_reg;
                wdt_hold_reg <= !idle_enable_on_halt_reg && !wdt_enabled_i;
            end else if (mode_reg != MODE_RUN && wake) begin
                cpu_run_reg  <= 1'b1;
                tbc_run_reg  <= 1'b1;
                wdt_hold_reg <= 1'b0;
            end
        end
    end

    // Power-down and expiry flags; the setting event wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pdf_reg <= 1'b0;
            to_reg  <= 1'b0;
        end else begin
            if (halt_take) begin
                pdf_reg <= 1'b1;
            end else if (clr_wdt_i) begin
                pdf_reg <= 1'b0;
            end
            if (wdt_overflow_i) begin
                to_reg <= 1'b1;
            end else if (halt_take) begin
                to_reg <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Oscillator control
    // ---------------------------------------------------------------
    // Fast osc runs only while a fast source is in use or wanted
    assign fast_if.run = (act_fast || tgt_fast)
                         && sys_on;
    assign slow_if.run = (mode_reg != MODE_DEEP_SLEEP_MODE);

    always_ff @(posedge clk_i) begin
        if (rst_i || !fast_if.run) begin
            fdiv_reg  <= '0;
            div16_reg <= 1'b0;
            div64_reg <= 1'b0;
        end else begin
            if (fast_if.tick) begin
                fdiv_reg <= fdiv_reg + 6'h01;
            end
            div16_reg <= fast_if.tick && (fdiv_reg[3:0] == 4'hf);
            div64_reg <= fast_if.tick && (fdiv_reg == 6'h3f);
        end
    end

    always_comb begin
        case (cks_act_reg)
            3'h2:    div_mask = 6'h3f;
            3'h3:    div_mask = 6'h1f;
            3'h4:    div_mask = 6'h0f;
            3'h5:    div_mask = 6'h07;
            3'h6:    div_mask = 6'h03;
            3'h7:    div_mask = 6'h01;
            default: div_mask = 6'h00;
        endcase
    end

    always_comb begin
        if (hl_act_reg) begin
            src_tick = fast_if.tick;
        end else if (act_fast) begin
            src_tick = fast_if.tick
                       && ((fdiv_reg & div_mask) == div_mask);
        end else begin
            src_tick = slow_if.tick;
        end
    end

    // ---------------------------------------------------------------
    // Source switch and system tick
    // ---------------------------------------------------------------
    // Change at a source tick, or at any time while the system clock is off, and only to a ready oscillator
    assign sw_ok = ((hl_act_reg != high_clock_select_reg) || (cks_act_reg != cks_reg))
                   && (tgt_fast ? fast_if.ready : slow_if.ready)
                   && (src_tick || !sys_on);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hl_act_reg  <= MODE_RESET[MODE_HIGH_CLOCK_SELECT_BIT];
            cks_act_reg <= MODE_RESET[7:MODE_CKS_LSB];
        end else if (sw_ok) begin
            hl_act_reg  <= high_clock_select_reg;
            cks_act_reg <= cks_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_tick_reg <= 1'b0;
            gap_reg      <= GAP_MAX;
        end else begin
            // Minimum spacing hides a short first pulse after a switch
            sys_tick_reg <= sys_on && src_tick
                            && (gap_reg >= MIN_GAP_M1);
            if (sys_on && src_tick && (gap_reg >= MIN_GAP_M1)) begin
                gap_reg <= '0;
            end else if (gap_reg != GAP_MAX) begin
                gap_reg <= gap_reg + 4'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cks_reg    <= MODE_RESET[7:MODE_CKS_LSB];
            idle_enable_on_halt_reg  <= MODE_RESET[MODE_IDLE_ENABLE_ON_HALT_BIT];
            high_clock_select_reg  <= MODE_RESET[MODE_HIGH_CLOCK_SELECT_BIT];
            idle_system_clock_keep_reg <= AUX_RESET[AUX_IDLE_SYSTEM_CLOCK_KEEP_BIT];
            d3_reg     <= AUX_RESET[AUX_D3_BIT];
        end else if (wr_en && wb_adr_i == ADDR_MODE) begin
            cks_reg   <= wb_dat_i[7:MODE_CKS_LSB];
            idle_enable_on_halt_reg <= wb_dat_i[MODE_IDLE_ENABLE_ON_HALT_BIT];
            high_clock_select_reg <= wb_dat_i[MODE_HIGH_CLOCK_SELECT_BIT];
        end else if (wr_en && wb_adr_i == ADDR_AUX) begin
            idle_system_clock_keep_reg <= wb_dat_i[AUX_IDLE_SYSTEM_CLOCK_KEEP_BIT];
            d3_reg     <= wb_dat_i[AUX_D3_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_voltage_reset_flag_reg <= AUX_RESET[AUX_LOW_VOLTAGE_RESET_FLAG_BIT];
            wrf_reg  <= AUX_RESET[AUX_WRF_BIT];
        end else begin
            if (lvr_event_i) begin
                low_voltage_reset_flag_reg <= 1'b1;
            end else if (wr_en && wb_adr_i == ADDR_AUX
                         && !wb_dat_i[AUX_LOW_VOLTAGE_RESET_FLAG_BIT]) begin
                low_voltage_reset_flag_reg <= 1'b0;
            end
            if (wdt_ctrl_reset_i) begin
                wrf_reg <= 1'b1;
            end else if (wr_en && wb_adr_i == ADDR_AUX
                         && !wb_dat_i[AUX_WRF_BIT]) begin
                wrf_reg <= 1'b0;
            end
        end
    end

    assign irq_ev[IRQ_HTO]    = fast_if.ready && !hto_d_reg;
    assign irq_ev[IRQ_LTO]    = slow_if.ready && !lto_d_reg;
    assign irq_ev[IRQ_WAKE]   = (mode_reg != MODE_RUN) && wake;
    assign irq_ev[IRQ_SWITCH] = sw_ok;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_st_reg  <= '0;
            irq_msk_reg <= '0;
            hto_d_reg   <= 1'b0;
            lto_d_reg   <= 1'b0;
            irq_reg     <= 1'b0;
        end else begin
            hto_d_reg <= fast_if.ready;
            lto_d_reg <= slow_if.ready;
            irq_reg   <= |(irq_st_reg & irq_msk_reg);
            if (wr_en && wb_adr_i == ADDR_IRQ_ST) begin
                irq_st_reg <= irq_ev | (irq_st_reg & ~wb_dat_i[IRQ_W-1:0]);
            end else begin
                irq_st_reg <= irq_ev | irq_st_reg;
            end
            if (wr_en && wb_adr_i == ADDR_IRQ_MSK) begin
                irq_msk_reg <= wb_dat_i[IRQ_W-1:0];
            end
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        case (wb_adr_i)
            ADDR_MODE: begin
                rdata_next[7:MODE_CKS_LSB]  = cks_reg;
                rdata_next[MODE_LTO_BIT]    = slow_if.ready;
                rdata_next[MODE_HTO_BIT]    = fast_if.ready;
                rdata_next[MODE_IDLE_ENABLE_ON_HALT_BIT]  = idle_enable_on_halt_reg;
                rdata_next[MODE_HIGH_CLOCK_SELECT_BIT]  = high_clock_select_reg;
            end
            ADDR_AUX: begin
                rdata_next[AUX_IDLE_SYSTEM_CLOCK_KEEP_BIT]  = idle_system_clock_keep_reg;
                rdata_next[AUX_D3_BIT]      = d3_reg;
                rdata_next[AUX_LOW_VOLTAGE_RESET_FLAG_BIT]    = low_voltage_reset_flag_reg;
                rdata_next[AUX_WRF_BIT]     = wrf_reg;
            end
            ADDR_STAT: begin
                rdata_next[STAT_PDF_BIT]    = pdf_reg;
                rdata_next[STAT_TO_BIT]     = to_reg;
            end
            ADDR_IRQ_ST:  rdata_next[IRQ_W-1:0] = irq_st_reg;
            ADDR_IRQ_MSK: rdata_next[IRQ_W-1:0] = irq_msk_reg;
            default:      rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg   <= bus_req;
            rdata_reg <= bus_req ? rdata_next : 32'h0000_0000;
        end
    end

    assign wb_ack_o               = ack_reg;
    assign wb_dat_o               = rdata_reg;
    assign sys_tick_o             = sys_tick_reg;
    assign cpu_run_o              = cpu_run_reg;
    assign tbc_run_o              = tbc_run_reg;
    assign slow_internal_osc_tick_o            = slow_if.tick;
    assign fast_div16_tick_o      = div16_reg;
    assign fast_div64_tick_o      = div64_reg;
    assign wdt_clear_o            = wdt_clear_reg;
    assign wdt_hold_o             = wdt_hold_reg;
    assign power_down_flag_o      = pdf_reg;
    assign watchdog_expiry_flag_o = to_reg;
    assign mode_o                 = mode_reg;
    assign irq_o                  = irq_reg;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_deep_sleep_mode_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        halt_take && !idle_enable_on_halt_reg && !wdt_enabled_i
        |=> mode_reg == MODE_DEEP_SLEEP_MODE && wdt_hold_reg && !cpu_run_reg)
        else $error("deep sleep not entered");
    a_sleep_with_watchdog_mode_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        halt_take && !idle_enable_on_halt_reg && wdt_enabled_i
        |=> mode_reg == MODE_SLEEP_WITH_WATCHDOG_MODE && !tbc_run_reg)
        else $error("watchdog sleep not entered");
    a_idle_clock_off_mode_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        halt_take && idle_enable_on_halt_reg && !idle_system_clock_keep_reg
        |=> mode_reg == MODE_IDLE_CLOCK_OFF_MODE ##1 !sys_tick_reg)
        else $error("idle clock off not entered");
    a_idle_clock_on_mode_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        halt_take && idle_enable_on_halt_reg && idle_system_clock_keep_reg
        |=> mode_reg == MODE_IDLE_CLOCK_ON_MODE && tbc_run_reg)
        else $error("idle clock on not entered");
    a_pdf_to_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        halt_take && !wdt_overflow_i |=> pdf_reg && !to_reg)
        else $error("power down flags wrong on entry");
    a_fast_stops: assert property (@(posedge clk_i) disable iff (rst_i)
        !act_fast && !tgt_fast |-> !fast_if.run ##1 !div16_reg)
        else $error("fast osc runs on slow clock");
    a_lto_deep: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg == MODE_DEEP_SLEEP_MODE && $past(mode_reg) == MODE_DEEP_SLEEP_MODE
        |-> !slow_if.ready)
        else $error("slow ready high in deep sleep");
    a_low_voltage_reset_flag_noset: assert property (@(posedge clk_i) disable iff (rst_i)
        !low_voltage_reset_flag_reg && !lvr_event_i |=> !low_voltage_reset_flag_reg)
        else $error("low voltage flag set by software");
    a_wrf_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        wrf_reg && !(wr_en && wb_adr_i == ADDR_AUX) |=> wrf_reg)
        else $error("reset flag cleared without write");
    a_switch_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        tgt_fast && !fast_if.ready
        |=> $stable(hl_act_reg) && $stable(cks_act_reg))
        else $error("switched to unready fast osc");
    a_wake_run: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg != MODE_RUN && wdt_overflow_i
        |=> mode_reg == MODE_RUN && cpu_run_reg)
        else $error("no wake on watchdog overflow");
    a_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
        sys_tick_reg |=> !sys_tick_reg [*4])
        else $error("system tick too close");

endmodule

// *** pkg/omcc_pkg.sv ***
package omcc_pkg;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ           = 50_000_000;
    localparam int FAST_HZ          = 8_000_000;
    localparam int SLOW_HZ          = 32_000;
    localparam int FAST_DIV         = (CLK_HZ + FAST_HZ / 2) / FAST_HZ;
    localparam int SLOW_DIV         = (CLK_HZ + SLOW_HZ / 2) / SLOW_HZ;
    localparam int FAST_START_TICKS = 16;
    localparam int SLOW_START_TICKS = 1;
    localparam int GAP_W            = 4;
    localparam logic [GAP_W-1:0] MIN_GAP_M1 = GAP_W'(FAST_DIV - 1);
    localparam logic [GAP_W-1:0] GAP_MAX    = 4'hf;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE    = 8'h00;
    localparam logic [7:0] ADDR_AUX     = 8'h04;
    localparam logic [7:0] ADDR_STAT    = 8'h08;
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h10;

    localparam int MODE_CKS_LSB   = 5;
    localparam int MODE_LTO_BIT   = 3;
    localparam int MODE_HTO_BIT   = 2;
    localparam int MODE_IDLE_ENABLE_ON_HALT_BIT = 1;
    localparam int MODE_HIGH_CLOCK_SELECT_BIT = 0;
    localparam int AUX_IDLE_SYSTEM_CLOCK_KEEP_BIT = 7;
    localparam int AUX_D3_BIT     = 3;
    localparam int AUX_LOW_VOLTAGE_RESET_FLAG_BIT   = 2;
    localparam int AUX_WRF_BIT    = 0;
    localparam int STAT_PDF_BIT   = 0;
    localparam int STAT_TO_BIT    = 1;

    localparam logic [7:0] MODE_RESET = 8'h03;
    localparam logic [7:0] AUX_RESET  = 8'h00;

    localparam logic [2:0] CKS_FIRST_FAST = 3'h2;

    localparam int IRQ_HTO    = 0;
    localparam int IRQ_LTO    = 1;
    localparam int IRQ_WAKE   = 2;
    localparam int IRQ_SWITCH = 3;
    localparam int IRQ_W      = 4;

    localparam int FDIV_W = 6;

    typedef enum logic [2:0] {
        MODE_RUN,
        MODE_DEEP_SLEEP_MODE,
        MODE_SLEEP_WITH_WATCHDOG_MODE,
        MODE_IDLE_CLOCK_OFF_MODE,
        MODE_IDLE_CLOCK_ON_MODE
    } omcc_mode_t;

endpackage

// *** pkg/omcc_osc_if.sv ***
`timescale 1ns/1ps
interface omcc_osc_if;
    logic run;
    logic tick;
    logic ready;

    modport osc  (input run, output tick, output ready);
    modport ctrl (output run, input tick, input ready);
endinterface

// *** hw/omcc_osc.sv ***
`timescale 1ns/1ps
module omcc_osc
    import omcc_pkg::*;
#(
    parameter int DIV   = 6,
    parameter int START = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    omcc_osc_if.osc  port_o
);

    logic [15:0] cnt_reg;
    logic [7:0]  start_reg;

    // ---------------------------------------------------------------
    // Oscillator tick
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || !port_o.run) begin
            cnt_reg     <= 16'h0000;
            port_o.tick <= 1'b0;
        end else begin
            port_o.tick <= (cnt_reg == 16'(DIV - 1));
            if (cnt_reg == 16'(DIV - 1)) begin
                cnt_reg <= 16'h0000;
            end else begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end

    // ---------------------------------------------------------------
    // Stability flag
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || !port_o.run) begin
            start_reg    <= 8'h00;
            port_o.ready <= 1'b0;
        end else if (port_o.tick && !port_o.ready) begin
            if (start_reg == 8'(START - 1)) begin
                port_o.ready <= 1'b1;
            end else begin
                start_reg <= start_reg + 8'h01;
            end
        end
    end

endmodule

// *** verif/omcc_tb_top.sv ***
`timescale 1ns/1ps
module operating_mode_clock_control_tb_top;
    import omcc_pkg::*;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, halt = 0;
    logic        wdt_en = 0, wov = 0, wcr = 0, lvr = 0, irqw = 0;
    logic [7:0]  adr = 0, pin = 8'hff;
    logic [31:0] dat = 0, rd, q;
    logic        ack, tick, cpu, tbc, hold, power_down_flag, tof, irq, d16, wclr;
    logic [2:0]  mode;
    int          miscompares = 0, cmp_count = 0, n, e;

    always #10 clk_i = ~clk_i;

    omcc_top u_omcc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .halt_i(halt),
        .wdt_enabled_i(wdt_en), .clr_wdt_i(1'b0), .wdt_overflow_i(wov),
        .wdt_ctrl_reset_i(wcr), .lvr_event_i(lvr), .irq_wake_i(irqw),
        .porta_pin_i(pin), .porta_wake_en_i(8'h01), .sys_tick_o(tick),
        .cpu_run_o(cpu), .tbc_run_o(tbc), .slow_internal_osc_tick_o(),
        .fast_div16_tick_o(d16), .fast_div64_tick_o(), .wdt_clear_o(wclr),
        .wdt_hold_o(hold), .power_down_flag_o(power_down_flag),
        .watchdog_expiry_flag_o(tof), .mode_o(mode), .irq_o(irq));

    task chk(input string s, input logic [31:0] ex, input logic [31:0] g);
        cmp_count++;
        if (g !== ex) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", s, ex, g);
        end
    endtask

    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rd;
        cyc <= 0; stb <= 0;
    endtask

    task poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
        n = 0;
        do begin wb(0, a, 0); n++; end while ((q[7:0] & m) != v && n < 1500);
        chk("poll", {24'h0, v}, {24'h0, q[7:0] & m});
    endtask

    task results;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        miscompares++;
        results;
    end

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        wb(0, ADDR_MODE, 0); chk("mode", 32'h03, q);
        poll(ADDR_MODE, 8'h04, 8'h04);
        wb(1, ADDR_AUX, 8'hff); wb(0, ADDR_AUX, 0); chk("aux", 32'h88, q);
        @(posedge clk_i); lvr <= 1; wcr <= 1;
        @(posedge clk_i); lvr <= 0; wcr <= 0;
        wb(1, ADDR_AUX, 8'h8d); wb(0, ADDR_AUX, 0); chk("aux", 32'h8d, q);
        wb(1, ADDR_AUX, 8'h08); wb(0, ADDR_AUX, 0); chk("aux", 32'h08, q);
        wb(0, 8'h40, 0); chk("unmapped", 0, q);
        for (int i = 0; i < 4; i++) begin
            wb(1, ADDR_MODE, {6'h0, i[1], 1'b1});
            wb(1, ADDR_AUX, {i[0], 7'h0});
            @(posedge clk_i); wdt_en <= i[0]; wov <= 1;
            @(posedge clk_i); wov <= 0; halt <= 1;
            @(posedge clk_i); halt <= 0;
            @(negedge clk_i);
            chk("mode", i[1] ? 3 + i[0] : 1 + i[0], mode);
            chk("pdf to", 2'b10, {power_down_flag, tof});
            chk("cpu", 0, cpu);
            chk("hold", i == 0, hold);
            chk("wdt clear", 1, wclr);
            chk("tbc", i[1], tbc);
            @(posedge clk_i);
            if (i[1]) irqw <= 1;
            else pin <= 8'hfe;
            n = 0;
            while (mode !== 0 && n < 8) begin @(posedge clk_i); n++; end
            chk("wake", 0, mode);
            irqw <= 0; pin <= 8'hff;
        end
        wb(1, ADDR_IRQ_MSK, 8'h04);
        wb(0, ADDR_IRQ_ST, 0); chk("irq st", 32'h04, q & 32'h04);
        chk("irq", 1, irq);
        wb(1, ADDR_IRQ_ST, 8'h04);
        wb(0, ADDR_IRQ_ST, 0); chk("irq st", 0, q & 32'h04);
        chk("irq", 0, irq);
        for (int c = 2; c < 9; c++) begin
            wb(1, ADDR_MODE, c == 8 ? 8'h41 : {c[2:0], 5'h0});
            e = c == 8 ? 128 : 768 / (6 << (8 - c));
            repeat (400) @(posedge clk_i);
            n = 0;
            repeat (768) begin @(posedge clk_i); n += tick; end
            chk("rate", 1, n >= e - 1 && n <= e + 1);
        end
        wb(1, ADDR_MODE, 8'h00);
        poll(ADDR_MODE, 8'h0c, 8'h08);
        n = 0;
        repeat (200) begin @(posedge clk_i); n += d16; end
        chk("div16 on slow", 0, n);
        wb(1, ADDR_MODE, 8'h01);
        poll(ADDR_MODE, 8'h04, 8'h04);
        results;
    end
endmodule
